// ---- design/fault_flag_irq_and_limit_cfg.sv ----
// fault flags, interrupt pin and phase 4/5 current limit registers
`timescale 1ns/1ps
`include "fault_flag_params.svh"

module fault_flag_irq_and_limit_cfg #(
	parameter int DATA_W = 8
) (
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   powerOnRst,
	input  wire fault_flag_pkg::regreq_s req,
	input  wire fault_flag_pkg::cond_s  cond,
	input  wire logic [1:0]             tempBand,
	output logic [7:0]                  rdata,
	output logic [1:0]                  phase4_current_limit,
	output logic [1:0]                  phase5_current_limit,
	output logic                        irqOut_n
);

	// =====================
	// elaboration check
	if (DATA_W != 8) begin : g_bad_width
		$error("register width must be 8");
	end

	typedef struct packed {
		logic [7:0] ph4;
		logic [7:0] ph5;
		logic [7:0] mask;
		logic [4:0] railRsvd;
		logic [1:0] evRsvd;
		logic [7:0] rdata;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic wrRail;
	logic wrEv;
	logic clrRail;
	logic clrSag;
	logic clrWarn;
	logic clrShut;
	logic clrOv;
	logic clrShort;
	logic clrLoad;
	logic fRail;
	logic fSag;
	logic fWarn;
	logic fShut;
	logic fOv;
	logic fShort;
	logic fLoad;
	logic irqAny;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		return req.wrEn && (a == base);
	endfunction : hit

	// =====================
	// flag clears: written zero only, write of one leaves flag alone
	assign wrRail   = hit(req.addr, `ADDR_RAIL_STATUS);
	assign wrEv     = hit(req.addr, `ADDR_EVENT_STATUS);
	assign clrRail  = wrRail && !req.wdata[`RAIL_FAULT_BIT];
	assign clrLoad  = wrEv && !req.wdata[`EV_LOAD_READY_BIT];
	assign clrSag   = wrEv && !req.wdata[`EV_SAG_BIT];
	assign clrWarn  = wrEv && !req.wdata[`EV_TWARN_BIT];
	assign clrShut  = wrEv && !req.wdata[`EV_TSHUT_BIT];
	assign clrOv    = wrEv && !req.wdata[`EV_OVERVOLT_BIT];
	assign clrShort = wrEv && !req.wdata[`EV_SHORT_BIT];

	// flags only reset on supply loss, not on soft reset
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_rail (
		.clk(clk), .srst(powerOnRst), .cond(cond.railFault), .clrReq(clrRail), .flag(fRail)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_load (
		.clk(clk), .srst(powerOnRst), .cond(cond.loadReady), .clrReq(clrLoad), .flag(fLoad)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_sag (
		.clk(clk), .srst(powerOnRst), .cond(cond.sag), .clrReq(clrSag), .flag(fSag)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_warn (
		.clk(clk), .srst(powerOnRst), .cond(cond.tWarn), .clrReq(clrWarn), .flag(fWarn)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b1)) u_shut (
		.clk(clk), .srst(powerOnRst), .cond(cond.tShut), .clrReq(clrShut), .flag(fShut)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_ov (
		.clk(clk), .srst(powerOnRst), .cond(cond.overVolt), .clrReq(clrOv), .flag(fOv)
	);
	sticky_flag #(.HOLD_OFF_AFTER_CLEAR(1'b0)) u_short (
		.clk(clk), .srst(powerOnRst), .cond(cond.shortOut), .clrReq(clrShort), .flag(fShort)
	);

	// =====================
	// interrupt: level, falls with flags, no pulse
	always_comb begin
		irqAny = (fRail && !st_r.mask[`RAIL_FAULT_BIT])
			|| (fOv && !st_r.mask[`EV_OVERVOLT_BIT])
			|| (fShort && !st_r.mask[`EV_SHORT_BIT])
			|| fLoad || fSag || fWarn || fShut;
	end
	assign irqOut_n = !irqAny;

	// =====================
	// register file
	always_comb begin
		st_nxt = st_r;
		if (req.wrEn) begin
			if (req.addr == `ADDR_PHASE4_CTRL) begin
				st_nxt.ph4 = req.wdata;
			end else if (req.addr == `ADDR_PHASE5_CTRL) begin
				st_nxt.ph5 = req.wdata;
			end else if (req.addr == `ADDR_RAIL_STATUS) begin
				st_nxt.railRsvd = req.wdata[7:3];
			end else if (req.addr == `ADDR_EVENT_STATUS) begin
				st_nxt.evRsvd = req.wdata[7:6];
			end else if (req.addr == `ADDR_IRQ_MASK) begin
				st_nxt.mask = req.wdata;
			end
		end
		// reads have no side effect on flags
		if (req.rdEn) begin
			if (req.addr == `ADDR_PHASE4_CTRL) begin
				st_nxt.rdata = st_r.ph4;
			end else if (req.addr == `ADDR_PHASE5_CTRL) begin
				st_nxt.rdata = st_r.ph5;
			end else if (req.addr == `ADDR_RAIL_STATUS) begin
				st_nxt.rdata = {st_r.railRsvd, fRail, tempBand};
			end else if (req.addr == `ADDR_EVENT_STATUS) begin
				st_nxt.rdata = {st_r.evRsvd, fLoad, fSag, fWarn, fShut, fOv, fShort};
			end else if (req.addr == `ADDR_IRQ_MASK) begin
				st_nxt.rdata = st_r.mask;
			end else begin
				st_nxt.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || powerOnRst) begin
			st_r.ph4      <= {`LIMIT_RESET, `PHASE_LOW_RESET};
			st_r.ph5      <= {`LIMIT_RESET, `PHASE_LOW_RESET};
			st_r.mask     <= {`MASK_HIGH_RESET, `MASK_LOW_RESET};
			st_r.railRsvd <= 5'h00;
			st_r.evRsvd   <= 2'h0;
			st_r.rdata    <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata                = st_r.rdata;
	assign phase4_current_limit = st_r.ph4[`LIMIT_MSB:`LIMIT_LSB];
	assign phase5_current_limit = st_r.ph5[`LIMIT_MSB:`LIMIT_LSB];

endmodule : fault_flag_irq_and_limit_cfg

// ---- design/fault_flag_params.svh ----
// register offsets, field positions and reset values of the fault flag block
`ifndef FAULT_FLAG_PARAMS_SVH
`define FAULT_FLAG_PARAMS_SVH

`define ADDR_PHASE4_CTRL    8'h0b
`define ADDR_PHASE5_CTRL    8'h0c
`define ADDR_RAIL_STATUS    8'h0d
`define ADDR_EVENT_STATUS   8'h0e
`define ADDR_IRQ_MASK       8'h0f

`define LIMIT_MSB           7
`define LIMIT_LSB           6
`define LIMIT_RESET         2'h2
`define PHASE_LOW_RESET     6'h11
`define MASK_HIGH_RESET     5'h1f
`define MASK_LOW_RESET      3'h0

`define RAIL_FAULT_BIT      2
`define EV_LOAD_READY_BIT   5
`define EV_SAG_BIT          4
`define EV_TWARN_BIT        3
`define EV_TSHUT_BIT        2
`define EV_OVERVOLT_BIT     1
`define EV_SHORT_BIT        0

`endif

// ---- design/fault_flag_pkg.sv ----
// types shared by the fault flag block
package fault_flag_pkg;

	typedef struct packed {
		logic railFault;
		logic sag;
		logic tWarn;
		logic tShut;
		logic overVolt;
		logic shortOut;
		logic loadReady;
	} cond_s;

	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wdata;
	} regreq_s;

endpackage : fault_flag_pkg

// ---- design/sticky_flag.sv ----
// one sticky flag with write-zero clear and optional re-arm inhibit
`timescale 1ns/1ps

module sticky_flag #(
	parameter bit HOLD_OFF_AFTER_CLEAR = 1'b0
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic cond,
	input  wire logic clrReq,
	output logic      flag
);

	typedef struct packed {
		logic flag;
		logic blocked;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic   setEv;

	// =====================
	// next state
	always_comb begin
		st_nxt = st_r;
		setEv  = cond && !(HOLD_OFF_AFTER_CLEAR && st_r.blocked);
		if (clrReq) begin
			st_nxt.flag    = 1'b0;
			st_nxt.blocked = cond;
		end
		if (!cond) begin
			st_nxt.blocked = 1'b0;
		end
		// set wins over a clear in the same cycle, except a held-off shutdown
		if (setEv && !(HOLD_OFF_AFTER_CLEAR && clrReq)) begin
			st_nxt.flag = 1'b1;
		end
	end

	// =====================
	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

endmodule : sticky_flag

// ---- dv/fault_flag_irq_and_limit_cfg_assertions.sv ----
// port checker of the fault flag block
`timescale 1ns/1ps
module fault_flag_checker (
	input wire logic                    clk,
	input wire logic                    srst,
	input wire logic                    powerOnRst,
	input wire fault_flag_pkg::regreq_s req,
	input wire fault_flag_pkg::cond_s   cond,
	input wire logic [1:0]              tempBand,
	input wire logic [7:0]              rdata,
	input wire logic [1:0]              phase4_current_limit,
	input wire logic [1:0]              phase5_current_limit,
	input wire logic                    irqOut_n
);
	// ====
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst || powerOnRst);
	sag_irq_a: assert property (cond.sag |=> !irqOut_n)
		else $error("sag irq");
	load_irq_a: assert property (cond.loadReady |=> !irqOut_n)
		else $error("load irq");
	warn_irq_a: assert property (cond.tWarn |=> !irqOut_n)
		else $error("warn irq");
	read_keeps_a: assert property (cond.sag ##1 (req.rdEn && !req.wrEn && req.addr == 8'h0e)
		|=> rdata[4])
		else $error("sag read");
	temp_ro_a: assert property (req.rdEn && req.addr == 8'h0d |=> rdata[1:0] == $past(tempBand))
		else $error("temp read");
	limit_hold_a: assert property (!(req.wrEn && req.addr == 8'h0b)
		|=> $stable(phase4_current_limit))
		else $error("ph4 hold");
	limit_write_a: assert property (req.wrEn && req.addr == 8'h0c
		|=> phase5_current_limit == $past(req.wdata[7:6]))
		else $error("ph5 write");
	rdata_hold_a: assert property (!req.rdEn |=> $stable(rdata))
		else $error("rdata hold");
	unmapped_a: assert property (req.rdEn && req.addr > 8'h0f |=> rdata == 8'h00)
		else $error("unmapped read");
	cover property (cond.shortOut ##1 !irqOut_n);
	cover property ($rose(irqOut_n));
	cover property (cond.tShut ##1 req.wrEn);
endmodule : fault_flag_checker

bind fault_flag_irq_and_limit_cfg fault_flag_checker chk (.clk(clk), .srst(srst),
	.powerOnRst(powerOnRst), .req(req), .cond(cond), .tempBand(tempBand), .rdata(rdata),
	.phase4_current_limit(phase4_current_limit), .phase5_current_limit(phase5_current_limit),
	.irqOut_n(irqOut_n));

// ---- dv/fault_flag_irq_and_limit_cfg_tb.sv ----
// self-checking bench of the fault flag block
`timescale 1ns/1ps
module fault_flag_irq_and_limit_cfg_tb;
	logic                    clk;
	logic                    srst;
	logic                    powerOnRst;
	fault_flag_pkg::regreq_s req;
	fault_flag_pkg::cond_s   cond;
	logic [1:0]              tempBand;
	logic [7:0]              rdata;
	logic [1:0]              lim4;
	logic [1:0]              lim5;
	logic                    irqOut_n;
	logic [7:0]              d;
	int                      failures;
	int                      checks;
	// address, write data, read back; last row unmapped
	logic [23:0] rows[6] = '{24'h0b0000, 24'h0caaaa, 24'h0b5555, 24'h0cffff, 24'h0f0707,
		24'h13ff00};
	host_model host (.clk(clk), .rdata(rdata), .req(req));
	fault_flag_irq_and_limit_cfg uut (.clk(clk), .srst(srst), .powerOnRst(powerOnRst),
		.req(req), .cond(cond), .tempBand(tempBand), .rdata(rdata),
		.phase4_current_limit(lim4), .phase5_current_limit(lim5), .irqOut_n(irqOut_n));
	// ====
	// helpers
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic pulse(input logic [6:0] c);
		@(posedge clk) #1;
		cond = c;
		@(posedge clk) #1;
		cond = '0;
	endtask : pulse
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// ====
	// stimulus
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// run needs under a hundred cycles
	initial begin
		#50us;
		failures++;
		test_done();
	end
	initial begin
		srst = 1'b1;
		powerOnRst = 1'b1;
		cond = '0;
		tempBand = 2'h0;
		repeat (16) @(posedge clk);
		#1;
		srst = 1'b0;
		powerOnRst = 1'b0;
		host.rd(8'h0b, d);
		check("ph4 reset", d, 8'h91);
		host.rd(8'h0f, d);
		check("mask reset", d, 8'hf8);
		foreach (rows[i]) begin
			host.wr(rows[i][23:16], rows[i][15:8]);
			host.rd(rows[i][23:16], d);
			check("row", d, rows[i][7:0]);
		end
		check("ph4 out", {6'h0, lim4}, 8'h01);
		check("ph5 out", {6'h0, lim5}, 8'h03);
		host.lim(2'h0);
		check("lim4 equal", {6'h0, lim4}, 8'h00);
		check("lim5 equal", {6'h0, lim5}, 8'h00);
		$display("table done");
		pulse(7'h02);
		check("short masked", {7'h0, irqOut_n}, 8'h01);
		host.wr(8'h0f, 8'hf8);
		check("short irq", {7'h0, irqOut_n}, 8'h00);
		srst = 1'b1;
		@(posedge clk) #1;
		srst = 1'b0;
		check("soft rst lim", {6'h0, lim4}, 8'h02);
		host.rd(8'h0e, d);
		host.wr(8'h0e, 8'h01);
		host.rd(8'h0e, d);
		check("flag kept", d, 8'h01);
		host.wr(8'h0e, 8'h00);
		check("irq freed", {7'h0, irqOut_n}, 8'h01);
		cond.overVolt = 1'b1;
		host.wr(8'h0e, 8'h00);
		host.rd(8'h0e, d);
		check("overvolt", d, 8'h02);
		check("overvolt irq", {7'h0, irqOut_n}, 8'h00);
		cond.overVolt = 1'b0;
		cond.tShut = 1'b1;
		host.wr(8'h0e, 8'h00);
		host.wr(8'h0e, 8'h00);
		host.rd(8'h0e, d);
		check("shutdown", d, 8'h00);
		cond.tShut = 1'b0;
		tempBand = 2'h2;
		pulse(7'h40);
		host.wr(8'h0f, 8'hfc);
		check("rail masked", {7'h0, irqOut_n}, 8'h01);
		host.rd(8'h0d, d);
		check("rail flag", d, 8'h06);
		host.wr(8'h0d, 8'h03);
		host.rd(8'h0d, d);
		check("temp ro", d, 8'h02);
		host.wr(8'h0f, 8'hff);
		pulse(7'h31);
		host.rd(8'h0e, d);
		check("events", d, 8'h38);
		check("no mask irq", {7'h0, irqOut_n}, 8'h00);
		// supply loss clears every flag and resets every register to its default
		powerOnRst = 1'b1;
		@(posedge clk) #1;
		powerOnRst = 1'b0;
		host.rd(8'h0e, d);
		check("supply loss", d, 8'h00);
		check("irq idle", {7'h0, irqOut_n}, 8'h01);
		host.rd(8'h0f, d);
		check("mask default", d, 8'hf8);
		$display("hand tests done");
		test_done();
	end
endmodule : fault_flag_irq_and_limit_cfg_tb

// ---- dv/host_model.sv ----
// host side model: register cycles on the request port
`timescale 1ns/1ps
module host_model (
	input  wire logic               clk,
	input  wire logic [7:0]         rdata,
	output fault_flag_pkg::regreq_s req
);
	// ====
	// bus cycles
	initial begin
		req = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		req = '{1'b1, 1'b0, a, d};
		@(posedge clk) #1;
		req = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) #1;
		req = '0;
		d = rdata;
	endtask : rd
	// same code on both phases
	task automatic lim(input logic [1:0] c);
		wr(8'h0b, {c, 6'h11});
		wr(8'h0c, {c, 6'h11});
	endtask : lim
endmodule : host_model
